// File: verilog/uurm_pkg.sv
// Shared constants and types for the serial channel register block
package uurm_pkg;

  // ********************************************************************
  // Register offsets (3-bit address)
  // ********************************************************************
  localparam logic [2:0] ADDR_DATA  = 3'h0;  // receive/transmit holding, divisor low
  localparam logic [2:0] ADDR_IER   = 3'h1;  // interrupt enable, divisor high
  localparam logic [2:0] ADDR_ISR   = 3'h2;  // interrupt source/fifo control, alternate function
  localparam logic [2:0] ADDR_LCR   = 3'h3;
  localparam logic [2:0] ADDR_MCR   = 3'h4;
  localparam logic [2:0] ADDR_LSR   = 3'h5;
  localparam logic [2:0] ADDR_MSR   = 3'h6;
  localparam logic [2:0] ADDR_SPR   = 3'h7;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int LCR_DLAB_BIT  = 7;
  localparam int LCR_BREAK_BIT = 6;
  localparam int LCR_FORCE_BIT = 5;
  localparam int LCR_EVEN_BIT  = 4;
  localparam int LCR_PEN_BIT   = 3;
  localparam int LCR_STOP_BIT  = 2;
  localparam int FCR_EN_BIT    = 0;
  localparam int FCR_RXRST_BIT = 1;
  localparam int FCR_TXRST_BIT = 2;
  localparam int FCR_DMA_BIT   = 3;
  localparam int IER_RXD_BIT   = 0;
  localparam int IER_TXE_BIT   = 1;
  localparam int IER_LS_BIT    = 2;
  localparam int IER_MS_BIT    = 3;

  // ********************************************************************
  // Reset values, interrupt codes, trigger levels
  // ********************************************************************
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [3:0] ISR_NONE     = 4'h1;
  localparam logic [3:0] ISR_LINE     = 4'h6;
  localparam logic [3:0] ISR_RXDATA   = 4'h4;
  localparam logic [3:0] ISR_TXREADY  = 4'h2;
  localparam logic [3:0] ISR_MODEM    = 4'h0;
  localparam logic [4:0] TRIG_LVL0    = 5'h01;
  localparam logic [4:0] TRIG_LVL1    = 5'h04;
  localparam logic [4:0] TRIG_LVL2    = 5'h08;
  localparam logic [4:0] TRIG_LVL3    = 5'h0E;
  localparam int         FIFO_DEPTH   = 16;
  localparam logic [3:0] TICKS_PER_BIT_M1 = 4'hF;  // 16x clock per bit

  // ********************************************************************
  // Carriers
  // ********************************************************************
  typedef struct packed {
    logic       brk;   // break tag
    logic       fe;    // framing error tag
    logic       pe;    // parity error tag
    logic [7:0] data;
  } uurm_rxchar_s;

  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } uurm_modem_in_s;

  typedef struct packed {
    logic op2_n;
    logic op1_n;
    logic rts_n;
    logic dtr_n;
  } uurm_modem_out_s;

endpackage

// File: verilog/uurm_fifo.sv
// Flip-flop FIFO with level count, used for receive and transmit
`timescale 1ns/100ps
module uurm_fifo
  import uurm_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_resetn,
  input  wire logic             i_clear,
  input  wire logic             i_push,
  input  wire logic [WIDTH-1:0] i_wdata,
  input  wire logic             i_pop,
  output logic      [WIDTH-1:0] o_rdata,
  output logic      [AW:0]      o_count
);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             do_push;
  logic             do_pop;

  // Caller guards full/empty; these guards only stop pointer wrap damage
  assign do_push = i_push && (count_reg != (AW+1)'(DEPTH)) && !i_clear;
  assign do_pop  = i_pop && (count_reg != '0) && !i_clear;
  assign o_rdata = mem_reg[rd_ptr_reg];
  assign o_count = count_reg;

  // ********************************************************************
  // Storage
  // ********************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= i_wdata;
    end
  end

  // Pointers and level; clear leaves storage contents alone
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (i_clear) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

endmodule

// File: verilog/uurm_baud_gen.sv
// Programmable divider that makes the 16x bit-clock enable
`timescale 1ns/100ps
module uurm_baud_gen
  import uurm_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_resetn,
  input  wire logic [DIV_W-1:0] i_divisor,
  output logic                  o_tick
);

  logic [DIV_W-1:0] cnt_reg;

  // Down counter reloads from the divisor; zero divisor stops the clock
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_reg <= '0;
      o_tick  <= 1'b0;
    end else if (i_divisor == '0) begin
      cnt_reg <= '0;
      o_tick  <= 1'b0;
    end else if (cnt_reg <= DIV_W'(1)) begin
      cnt_reg <= i_divisor;  // 16-bit divide value sets the rate
      o_tick  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg - 1'b1;
      o_tick  <= 1'b0;
    end
  end

endmodule

// File: verilog/uurm_top.sv
// One serial channel: register map, interrupts, FIFOs and transmitter
`timescale 1ns/100ps
module uurm_top
  import uurm_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic            i_clk_sys,
  input  wire logic            i_resetn,
  input  wire logic [2:0]      i_addr,
  input  wire logic            i_rd,
  input  wire logic            i_wr,
  input  wire logic [7:0]      i_wdata,
  output logic      [7:0]      o_rdata,
  input  wire logic            i_rx_valid,
  input  wire uurm_rxchar_s    i_rx_char,
  input  wire uurm_modem_in_s  i_modem,
  output uurm_modem_out_s      o_modem,
  output logic                 o_txd,
  output logic                 o_irq,
  output logic                 o_receive_ready_pin_n
);

  localparam int AW = $clog2(DEPTH);

  // ********************************************************************
  // Registers and internal signals
  // ********************************************************************
  logic [7:0]    dll_reg;
  logic [7:0]    dlm_reg;
  logic [3:0]    ier_reg;
  logic [7:0]    lcr_reg;
  logic [4:0]    mcr_reg;
  logic [7:0]    spr_reg;
  logic [2:0]    afr_reg;
  logic          fifo_en_reg;
  logic          dma_reg;
  logic [1:0]    trig_sel_reg;
  logic          rx_clr_reg;
  logic          tx_clr_reg;
  logic          overrun_reg;
  logic          line_int_reg;
  logic          tx_int_reg;
  logic          head_new_reg;
  logic          tx_empty_prev_reg;
  logic [3:0]    msr_delta_reg;
  uurm_modem_in_s modem_prev_reg;
  logic [AW:0]   err_cnt_reg;
  logic          dlab;
  logic          rd_rhr;
  logic          wr_thr;
  logic          rd_lsr;
  logic          rd_isr;
  logic          rd_msr;
  uurm_rxchar_s  rx_head;
  logic [AW:0]   rx_count;
  logic [AW:0]   tx_count;
  logic [7:0]    tx_head;
  logic          rx_full;
  logic          tx_full;
  logic          rx_push;
  logic          rx_pop;
  logic          tx_push;
  logic          tx_pop;
  logic          rx_ovr_evt;
  logic          rx_data_int;
  logic          ms_int;
  logic [3:0]    isr_code;
  logic [4:0]    trig_lvl;
  logic [7:0]    line_status;
  logic          tick;
  logic          tsr_idle;

  // Line status reads 1-4 feed the line interrupt, head tags are live
  function automatic logic head_err(input uurm_rxchar_s c);
    return c.brk | c.fe | c.pe;
  endfunction

  // Receive trigger level decode
  function automatic logic [4:0] trig_decode(input logic [1:0] sel);
    unique case (sel)
      2'b00: return TRIG_LVL0;
      2'b01: return TRIG_LVL1;
      2'b10: return TRIG_LVL2;
      2'b11: return TRIG_LVL3;
    endcase
  endfunction

  // ********************************************************************
  // Address decode
  // ********************************************************************
  assign dlab   = lcr_reg[LCR_DLAB_BIT];
  assign rd_rhr = i_rd && i_addr == ADDR_DATA && !dlab;
  assign wr_thr = i_wr && i_addr == ADDR_DATA && !dlab;
  assign rd_isr = i_rd && i_addr == ADDR_ISR && !dlab;
  assign rd_lsr = i_rd && i_addr == ADDR_LSR;
  assign rd_msr = i_rd && i_addr == ADDR_MSR;

  // Non-FIFO mode behaves as a one-deep FIFO
  assign rx_full  = fifo_en_reg ? (rx_count == (AW+1)'(DEPTH)) : (rx_count != '0);
  assign tx_full  = fifo_en_reg ? (tx_count == (AW+1)'(DEPTH)) : (tx_count != '0);
  assign rx_push  = i_rx_valid && !rx_full;
  assign rx_ovr_evt = i_rx_valid && rx_full;  // New character is dropped
  assign rx_pop   = rd_rhr && rx_count != '0;
  assign tx_push  = wr_thr && !tx_full;
  assign trig_lvl = fifo_en_reg ? trig_decode(trig_sel_reg) : TRIG_LVL0;

  // ********************************************************************
  // FIFOs and baud generator
  // ********************************************************************
  uurm_fifo #(
    .WIDTH ($bits(uurm_rxchar_s)),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_clear   (rx_clr_reg),
    .i_push    (rx_push),
    .i_wdata   (i_rx_char),
    .i_pop     (rx_pop),
    .o_rdata   (rx_head),
    .o_count   (rx_count)
  );

  uurm_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH)
  ) u_tx_fifo (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_clear   (tx_clr_reg),
    .i_push    (tx_push),
    .i_wdata   (i_wdata),
    .i_pop     (tx_pop),
    .o_rdata   (tx_head),
    .o_count   (tx_count)
  );

  uurm_baud_gen #(
    .DIV_W (16)
  ) u_baud_gen (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_divisor ({dlm_reg, dll_reg}),
    .o_tick    (tick)
  );

  // ********************************************************************
  // Host-written configuration
  // ********************************************************************
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      dll_reg <= REG_RESET;
      dlm_reg <= REG_RESET;
      ier_reg <= '0;        // All sources disabled
      lcr_reg <= REG_RESET;
      mcr_reg <= '0;
      spr_reg <= REG_RESET;
      afr_reg <= '0;
    end else if (i_wr) begin
      unique case (i_addr)
        ADDR_DATA: if (dlab) begin
          dll_reg <= i_wdata;
        end
        ADDR_IER: if (dlab) begin
          dlm_reg <= i_wdata;
        end else begin
          ier_reg <= i_wdata[3:0];
        end
        ADDR_ISR: if (dlab) begin
          afr_reg <= i_wdata[2:0];
        end
        ADDR_LCR: lcr_reg <= i_wdata;
        ADDR_MCR: mcr_reg <= i_wdata[4:0];
        ADDR_SPR: spr_reg <= i_wdata;
        ADDR_LSR, ADDR_MSR: ;
      endcase
    end
  end

  // FIFO control; other bits only take effect with the enable bit set
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      fifo_en_reg  <= 1'b0;
      dma_reg      <= 1'b0;
      trig_sel_reg <= 2'b00;
      rx_clr_reg   <= 1'b0;
      tx_clr_reg   <= 1'b0;
    end else begin
      rx_clr_reg <= 1'b0;
      tx_clr_reg <= 1'b0;
      if (i_wr && i_addr == ADDR_ISR && !dlab) begin
        fifo_en_reg <= i_wdata[FCR_EN_BIT];
        if (i_wdata[FCR_EN_BIT]) begin
          dma_reg      <= i_wdata[FCR_DMA_BIT];
          trig_sel_reg <= i_wdata[7:6];
          rx_clr_reg   <= i_wdata[FCR_RXRST_BIT];
          tx_clr_reg   <= i_wdata[FCR_TXRST_BIT];
        end
      end
    end
  end

  // ********************************************************************
  // Receive status tracking
  // ********************************************************************
  // Count of error-tagged characters anywhere in the receive FIFO
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      err_cnt_reg <= '0;
    end else if (rx_clr_reg) begin
      err_cnt_reg <= '0;
    end else begin
      err_cnt_reg <= err_cnt_reg + (AW+1)'(rx_push && head_err(i_rx_char))
                     - (AW+1)'(rx_pop && head_err(rx_head));
    end
  end

  // Overrun and line interrupt are sticky; a set beats a same-cycle clear
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      overrun_reg  <= 1'b0;
      line_int_reg <= 1'b0;
      head_new_reg <= 1'b0;
    end else begin
      head_new_reg <= (rx_pop && rx_count > (AW+1)'(1)) || (rx_push && rx_count == '0);
      if (rx_ovr_evt) begin
        overrun_reg <= 1'b1;
      end else if (rd_lsr) begin
        overrun_reg <= 1'b0;
      end
      if (rx_ovr_evt) begin
        line_int_reg <= 1'b1;                         // Immediate on overrun
      end else if (head_new_reg && rx_count != '0 && head_err(rx_head)) begin
        line_int_reg <= 1'b1;                         // Only once at read position
      end else if (rd_lsr) begin
        line_int_reg <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Transmitter ready and modem deltas
  // ********************************************************************
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_empty_prev_reg <= 1'b1;
      tx_int_reg        <= 1'b0;
    end else begin
      tx_empty_prev_reg <= tx_count == '0;
      if (tx_count == '0 && !tx_empty_prev_reg) begin
        tx_int_reg <= 1'b1;                           // FIFO just drained
      end else if (wr_thr || (rd_isr && isr_code == ISR_TXREADY)) begin
        tx_int_reg <= 1'b0;
      end
    end
  end

  // Ring delta flags the end of a ring; others flag any change
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      modem_prev_reg <= '1;
      msr_delta_reg  <= '0;
    end else begin
      modem_prev_reg <= i_modem;
      for (int i = 0; i < 4; i++) begin
        if ((i == 2) ? (i_modem[i] && !modem_prev_reg[i]) : (i_modem[i] != modem_prev_reg[i])) begin
          msr_delta_reg[i] <= 1'b1;
        end else if (rd_msr) begin
          msr_delta_reg[i] <= 1'b0;
        end
      end
    end
  end

  // ********************************************************************
  // Interrupt priority
  // ********************************************************************
  // Receive level: trigger in FIFO mode, any data otherwise
  assign rx_data_int = ier_reg[IER_RXD_BIT] && rx_count >= (AW+1)'(trig_lvl);
  assign ms_int      = ier_reg[IER_MS_BIT] && msr_delta_reg != '0;

  // Highest pending unmasked source wins
  always_comb begin
    if (ier_reg[IER_LS_BIT] && line_int_reg) begin
      isr_code = ISR_LINE;
    end else if (rx_data_int) begin
      isr_code = ISR_RXDATA;
    end else if (ier_reg[IER_TXE_BIT] && tx_int_reg) begin
      isr_code = ISR_TXREADY;
    end else if (ms_int) begin
      isr_code = ISR_MODEM;
    end else begin
      isr_code = ISR_NONE;                            // Bit 0 high means idle
    end
  end

  // Line status; each direction reads its own bits
  assign line_status = {err_cnt_reg != '0,
                tx_count == '0 && tsr_idle,
                tx_count == '0,
                (rx_count != '0) ? {rx_head.brk, rx_head.fe, rx_head.pe} : 3'b000,
                overrun_reg,
                rx_count != '0};

  // ********************************************************************
  // Read data and registered outputs
  // ********************************************************************
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= REG_RESET;
    end else if (i_rd) begin
      unique case (i_addr)
        ADDR_DATA: o_rdata <= dlab ? dll_reg : rx_head.data;
        ADDR_IER:  o_rdata <= dlab ? dlm_reg : {4'h0, ier_reg};
        ADDR_ISR:  o_rdata <= dlab ? {5'h00, afr_reg}
                                   : {{2{fifo_en_reg}}, 2'b00, isr_code};
        ADDR_LCR:  o_rdata <= lcr_reg;
        ADDR_MCR:  o_rdata <= {3'b000, mcr_reg};
        ADDR_LSR:  o_rdata <= line_status;
        ADDR_MSR:  o_rdata <= {~i_modem, msr_delta_reg};
        ADDR_SPR:  o_rdata <= spr_reg;
      endcase
    end
  end

  // Pins track their controls one cycle behind
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq                 <= 1'b0;
      o_modem               <= '1;
      o_receive_ready_pin_n <= 1'b1;
    end else begin
      o_irq                 <= isr_code != ISR_NONE;
      o_modem               <= ~mcr_reg[3:0];
      o_receive_ready_pin_n <= dma_reg ? !(rx_count >= (AW+1)'(trig_lvl)) : (rx_count == '0);
    end
  end

  // ********************************************************************
  // Transmit shift register
  // ********************************************************************
  typedef enum logic {TX_IDLE, TX_SHIFT} uurm_tx_e;
  uurm_tx_e   tx_state_reg;
  logic [11:0] frame_reg;
  logic [3:0]  bits_left_reg;
  logic [3:0]  sub_reg;
  logic [11:0] frame_next;
  logic [3:0]  nbits;
  logic        par;

  assign tsr_idle = tx_state_reg == TX_IDLE;
  assign tx_pop   = tsr_idle && tx_count != '0;
  assign nbits    = 4'h5 + {2'b00, lcr_reg[1:0]};

  // Frame: start, data LSB first, optional parity, stop marks
  always_comb begin
    par        = ^(tx_head & ~(8'hFF << nbits));
    if (lcr_reg[LCR_FORCE_BIT]) begin
      par = !lcr_reg[LCR_EVEN_BIT];
    end else if (!lcr_reg[LCR_EVEN_BIT]) begin
      par = !par;
    end
    frame_next = 12'hFFE;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(nbits)) begin
        frame_next[i+1] = tx_head[i];
      end
    end
    if (lcr_reg[LCR_PEN_BIT]) begin
      frame_next[nbits+4'h1] = par;
    end
  end

  // Sixteen baud ticks per bit; long stop rounds to two bits
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_state_reg  <= TX_IDLE;
      frame_reg     <= '1;
      bits_left_reg <= '0;
      sub_reg       <= '0;
    end else begin
      unique case (tx_state_reg)
        TX_IDLE: if (tx_pop) begin
          frame_reg     <= frame_next;
          bits_left_reg <= nbits + 4'h2 + {3'b000, lcr_reg[LCR_PEN_BIT]}
                           + {3'b000, lcr_reg[LCR_STOP_BIT]};
          sub_reg       <= '0;
          tx_state_reg  <= TX_SHIFT;
        end
        TX_SHIFT: if (tick) begin
          sub_reg <= sub_reg + 1'b1;
          if (sub_reg == TICKS_PER_BIT_M1) begin
            frame_reg     <= {1'b1, frame_reg[11:1]};
            bits_left_reg <= bits_left_reg - 1'b1;
            if (bits_left_reg == 4'h1) begin
              tx_state_reg <= TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Break forces space; loopback holds the line at mark
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_txd <= 1'b1;
    end else begin
      o_txd <= lcr_reg[LCR_BREAK_BIT] ? 1'b0 :
               mcr_reg[4] ? 1'b1 :
               tsr_idle ? 1'b1 : frame_reg[0];
    end
  end

endmodule

// File: sim/uurm_props.sv
// Checker bound to the serial channel register block
`timescale 1ns/100ps
module uurm_props
  import uurm_pkg::*;
(
  input wire logic       i_clk_sys,
  input wire logic       i_resetn,
  input wire logic [2:0] i_addr,
  input wire logic       i_rd,
  input wire logic       i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic       i_rx_valid,
  input wire logic       o_irq
);
  logic       dlab_reg;
  logic       have_reg;
  logic       quiet_reg;
  logic [7:0] ier_reg;
  logic [7:0] dll_reg;
  logic [7:0] spr_reg;
  wire        rd_lsr = i_rd && i_addr == ADDR_LSR;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // Shadows of host writes, so each read knows what it owes
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      dlab_reg <= 1'b0;
      {ier_reg, dll_reg, spr_reg} <= 24'h000000;
    end else if (i_wr) begin
      if (i_addr == ADDR_LCR) dlab_reg <= i_wdata[LCR_DLAB_BIT];
      if (i_addr == ADDR_IER && !dlab_reg) ier_reg <= {4'h0, i_wdata[3:0]};
      if (i_addr == ADDR_DATA && dlab_reg) dll_reg <= i_wdata;
      if (i_addr == ADDR_SPR) spr_reg <= i_wdata;
    end
  end
  // Receive bookkeeping; conservative, any pop or fifo write drops the claim
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      have_reg  <= 1'b0;
      quiet_reg <= 1'b1;
    end else begin
      if (i_rx_valid) have_reg <= 1'b1;
      else if (!dlab_reg && (i_rd && i_addr == ADDR_DATA || i_wr && i_addr == ADDR_ISR)) have_reg <= 1'b0;
      if (i_rx_valid) quiet_reg <= 1'b0;
      else if (rd_lsr) quiet_reg <= 1'b1;
    end
  end
  property p_div; i_rd && i_addr == ADDR_DATA && dlab_reg |=> o_rdata == dll_reg; endproperty
  a_div: assert property (p_div) else $error("divisor readback wrong");
  property p_ier; i_rd && i_addr == ADDR_IER && !dlab_reg |=> o_rdata == ier_reg; endproperty
  a_ier: assert property (p_ier) else $error("enable readback wrong");
  property p_spr; i_rd && i_addr == ADDR_SPR |=> o_rdata == spr_reg; endproperty
  a_spr: assert property (p_spr) else $error("scratch readback wrong");
  property p_isr; i_rd && i_addr == ADDR_ISR && !dlab_reg |=> o_rdata[5:4] == 2'h0 && o_rdata[7] == o_rdata[6]; endproperty
  a_isr: assert property (p_isr) else $error("source reserved bits wrong");
  property p_temt; rd_lsr |=> !o_rdata[6] || o_rdata[5]; endproperty
  a_temt: assert property (p_temt) else $error("shifter empty without fifo empty");
  property p_rdy; rd_lsr && have_reg |=> o_rdata[0]; endproperty
  a_rdy: assert property (p_rdy) else $error("data ready missing");
  property p_ovr; rd_lsr && quiet_reg && !i_rx_valid |=> !o_rdata[1]; endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not cleared by read");
  property p_mask; (ier_reg == 8'h00) [*3] |-> !o_irq; endproperty
  a_mask: assert property (p_mask) else $error("interrupt while all masked");
  c_div: cover property (p_div);
  c_irq: cover property ($rose(o_irq));
  c_rdy: cover property (rd_lsr && have_reg);
endmodule

// File: sim/uurm_host.sv
// Host processor model on the parallel register port
`timescale 1ns/100ps
module uurm_host (
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_rdata,
  output logic      [2:0] o_addr,
  output logic            o_rd,
  output logic            o_wr,
  output logic      [7:0] o_wdata
);
  // Idle bus at time zero
  initial {o_addr, o_rd, o_wr, o_wdata} = 13'h0000;
  // One write; address and data are scrambled after release to expose late sampling
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk_sys);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask
  // One read; data is registered, so take it after the following edge
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk_sys);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    @(posedge i_clk_sys);
    #1 d = i_rdata;
  endtask
endmodule

// File: sim/tb.sv
// Self-checking testbench for the serial channel register block
`timescale 1ns/100ps
module tb
  import uurm_pkg::*;
();
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         rxv = 1'b0;
  uurm_rxchar_s rxc = 11'h000;
  logic [2:0]   addr;
  logic         rd;
  logic         wr;
  logic [7:0]   wd;
  logic [7:0]   rdata;
  logic [7:0]   d;
  logic         irq;
  logic         txd;
  logic         rrdy_n;
  uurm_modem_out_s mo;
  int           fail_count = 0;
  int           samples_checked = 0;
  uurm_host u_host (.i_clk_sys(clk), .i_rdata(rdata), .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wd));
  uurm_top u_uurm_top (.i_clk_sys(clk), .i_resetn(rst_n), .i_addr(addr), .i_rd(rd), .i_wr(wr), .i_wdata(wd),
    .o_rdata(rdata), .i_rx_valid(rxv), .i_rx_char(rxc), .i_modem(4'hF), .o_modem(mo), .o_txd(txd), .o_irq(irq),
    .o_receive_ready_pin_n(rrdy_n));
  // 20 MHz clock
  initial forever #25 clk = ~clk;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    u_host.rd(a, d);
    chk(d, e);
  endtask
  // Serial side hands over one character; the strobe drops for a cycle between calls
  task automatic push(input logic [10:0] c);
    @(posedge clk);
    rxv <= 1'b1;
    rxc <= c;
    @(posedge clk);
    rxv <= 1'b0;
    rxc <= ~c;
  endtask
  task automatic wirq(input logic e);
    int n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (irq !== e && n < 800);
    chk({7'h00, irq}, {7'h00, e});
  endtask
  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic t_reset();
    rc(ADDR_IER, 8'h00);
    rc(ADDR_ISR, 8'h01);
    rc(ADDR_LSR, 8'h60);
    chk({3'h0, rrdy_n, mo}, 8'h1F);
  endtask
  task automatic t_map();
    u_host.wr(ADDR_LCR, 8'h83);
    u_host.wr(ADDR_DATA, 8'h02);
    u_host.wr(ADDR_IER, 8'h00);
    rc(ADDR_DATA, 8'h02);
    u_host.wr(ADDR_LCR, 8'h03);
    u_host.wr(ADDR_IER, 8'hFF);
    rc(ADDR_IER, 8'h0F);
    u_host.wr(ADDR_LCR, 8'h83);
    rc(ADDR_IER, 8'h00);
    u_host.wr(ADDR_LCR, 8'h03);
    u_host.wr(ADDR_SPR, 8'hA5);
    rc(ADDR_SPR, 8'hA5);
  endtask
  task automatic t_rx();
    int i;
    u_host.wr(ADDR_ISR, 8'h41);
    u_host.wr(ADDR_IER, 8'h01);
    for (i = 0; i < 3; i++) push({3'h0, 8'h10 + 8'(i)});
    rc(ADDR_ISR, 8'hC1);
    push(11'h013);
    wirq(1'b1);
    rc(ADDR_ISR, 8'hC4);
    rc(ADDR_DATA, 8'h10);
    wirq(1'b0);
    u_host.wr(ADDR_IER, 8'h00);
    rc(ADDR_LSR, 8'h61);
    for (i = 1; i < 4; i++) rc(ADDR_DATA, 8'h10 + 8'(i));
    rc(ADDR_LSR, 8'h60);
  endtask
  task automatic t_line();
    u_host.wr(ADDR_IER, 8'h04);
    push(11'h0AA);
    push(11'h155);
    rc(ADDR_ISR, 8'hC1);
    rc(ADDR_LSR, 8'hE1);
    rc(ADDR_DATA, 8'hAA);
    wirq(1'b1);
    rc(ADDR_ISR, 8'hC6);
    rc(ADDR_LSR, 8'hE5);
    rc(ADDR_ISR, 8'hC1);
    rc(ADDR_DATA, 8'h55);
    rc(ADDR_LSR, 8'h60);
  endtask
  task automatic t_ovr();
    u_host.wr(ADDR_ISR, 8'h00);
    u_host.wr(ADDR_IER, 8'h05);
    push(11'h031);
    wirq(1'b1);
    rc(ADDR_ISR, 8'h04);
    push(11'h032);
    rc(ADDR_ISR, 8'h06);
    u_host.rd(ADDR_LSR, d);
    chk(d & 8'h7F, 8'h63);
    rc(ADDR_DATA, 8'h31);
    rc(ADDR_ISR, 8'h01);
  endtask
  // One 8N1 character at divisor 2 keeps the shifter busy 320 cycles
  task automatic t_tx();
    u_host.wr(ADDR_ISR, 8'h01);
    u_host.wr(ADDR_IER, 8'h02);
    u_host.wr(ADDR_DATA, 8'h55);
    wirq(1'b1);
    rc(ADDR_LSR, 8'h20);
    rc(ADDR_ISR, 8'hC2);
    wirq(1'b0);
    repeat (280) @(posedge clk);
    rc(ADDR_LSR, 8'h20);
    repeat (50) @(posedge clk);
    rc(ADDR_LSR, 8'h60);
    chk({7'h00, txd}, 8'h01);
  endtask
  task automatic final_report();
    $display("checked=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Main sequence after a ten-cycle reset
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_map();
    t_rx();
    t_line();
    t_ovr();
    t_tx();
    final_report();
  end
  // Watchdog, far beyond the roughly 500 cycles the scenarios need
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report();
  end
endmodule
bind uurm_top uurm_props u_props (.i_clk_sys, .i_resetn, .i_addr, .i_rd, .i_wr, .i_wdata, .o_rdata, .i_rx_valid, .o_irq);
